/* core/ccmd_pkg.sv */
package ccmd_pkg;

   // Clock and shared fast clock rates
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned FAST_HZ       = 8_000_000;
   localparam int unsigned FAST_DIV      = CLK_HZ / FAST_HZ;
   localparam int unsigned FAST_HIGH     = FAST_DIV / 2;

   // Counter population
   localparam int unsigned NUM_CNT       = 12;
   localparam int unsigned NUM_MUXED     = 10;
   localparam logic [2:0]  MODE_MAX      = 3'h5;

   // Register byte offsets
   localparam logic [11:0] OFS_CLK_SEL   = 12'h000;
   localparam logic [11:0] OFS_FAST_SEL  = 12'h004;
   localparam logic [11:0] OFS_DOUT0     = 12'h008;
   localparam logic [11:0] OFS_DOUT1     = 12'h00C;
   localparam logic [11:0] OFS_DIN0      = 12'h010;
   localparam logic [11:0] OFS_DIN1      = 12'h014;
   localparam logic [11:0] OFS_CH_SET    = 12'h018;
   localparam logic [11:0] OFS_CH_CLR    = 12'h01C;
   localparam logic [11:0] OFS_CARD_ID   = 12'h020;
   localparam logic [11:0] OFS_CNT_BASE  = 12'h040;

   // Field positions
   localparam int unsigned CNT_MODE_LSB  = 16;
   localparam int unsigned CH_PORT_BIT   = 3;

   // Clock-source select codes
   localparam logic [1:0]  SRC_EXT       = 2'h0;
   localparam logic [1:0]  SRC_PREV      = 2'h1;
   localparam logic [1:0]  SRC_FAST      = 2'h2;
   localparam logic [1:0]  SRC_LAST      = 2'h3;

   // Reset values
   localparam logic [19:0] RST_CLK_SEL   = 20'h00000;
   localparam logic        RST_FAST_SEL  = 1'b0;
   localparam logic [7:0]  RST_DOUT      = 8'h00;
   localparam logic [2:0]  RST_MODE      = 3'h0;
   localparam logic [15:0] RST_COUNT     = 16'h0000;

   // Per-counter programmed setup
   typedef struct packed {
      logic [2:0]  mode;
      logic [15:0] count;
   } ccmd_cfg_t;

endpackage

/* core/ccmd_top.sv */
`timescale 1ns/1ps

module ccmd_top (
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   input  wire logic        i_clock_en,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [9:0]  i_ext_clock,
   input  wire logic [7:0]  i_din0,
   input  wire logic [7:0]  i_din1,
   input  wire logic [1:0]  i_card_jumper,
   output logic      [11:0] o_counter_out,
   output logic      [7:0]  o_dout0,
   output logic      [7:0]  o_dout1
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [9:0][1:0]         counter_clock_select;
   logic                    fast_select;
   logic [1:0][7:0]         dout;
   ccmd_pkg::ccmd_cfg_t     cfg [ccmd_pkg::NUM_CNT];
   logic [15:0]             cnt [ccmd_pkg::NUM_CNT];
   logic [11:0]             cnt_out;
   logic [11:0]             src;
   logic [11:0]             src_q;
   logic [9:0]              sel_hold;
   logic [2:0]              fast_div;
   logic [31:0]             rdata_q;
   logic                    err_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        setup   = i_psel & ~i_penable;
   wire        access  = i_psel & i_penable & i_clock_en;
   wire        wr_en   = access & i_pwrite & ~err_q;
   wire [11:0] cnt_ofs = i_paddr - ccmd_pkg::OFS_CNT_BASE;
   wire [3:0]  cnt_idx = cnt_ofs[5:2];
   wire        in_cnt  = (i_paddr >= ccmd_pkg::OFS_CNT_BASE)
                       && (cnt_idx < 4'(ccmd_pkg::NUM_CNT))
                       && (cnt_ofs[11:6] == 6'h00)
                       && (i_paddr[1:0] == 2'h0);
   wire        hit_sel  = i_paddr == ccmd_pkg::OFS_CLK_SEL;
   wire        hit_fast = i_paddr == ccmd_pkg::OFS_FAST_SEL;
   wire        hit_do0  = i_paddr == ccmd_pkg::OFS_DOUT0;
   wire        hit_do1  = i_paddr == ccmd_pkg::OFS_DOUT1;
   wire        hit_di0  = i_paddr == ccmd_pkg::OFS_DIN0;
   wire        hit_di1  = i_paddr == ccmd_pkg::OFS_DIN1;
   wire        hit_set  = i_paddr == ccmd_pkg::OFS_CH_SET;
   wire        hit_clr  = i_paddr == ccmd_pkg::OFS_CH_CLR;
   wire        hit_id   = i_paddr == ccmd_pkg::OFS_CARD_ID;
   wire        hit_any  = hit_sel | hit_fast | hit_do0 | hit_do1
                        | hit_di0 | hit_di1 | hit_set | hit_clr
                        | hit_id | in_cnt;
   wire [2:0]  wr_mode  = i_pwdata[ccmd_pkg::CNT_MODE_LSB +: 3];
   // Modes above 5 are refused rather than stored
   wire        bad_mode = i_pwrite & in_cnt
                        & (wr_mode > ccmd_pkg::MODE_MAX);
   wire        bad_req  = ~hit_any | bad_mode;

   // Single-channel mask; port chosen by one bit, channel by three
   wire        ch_port  = i_pwdata[ccmd_pkg::CH_PORT_BIT];
   wire [7:0]  ch_mask  = 8'h01 << i_pwdata[2:0];
   wire [2:0]  card_num = {1'b0, i_card_jumper} + 3'h1;

   // Read mux, sampled in the setup phase so read data is a flop
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = 32'h00000000;
      if (hit_sel)
         next_rdata = {12'h000, counter_clock_select};
      else if (hit_fast)
         next_rdata = {31'h00000000, fast_select};
      else if (hit_do0)
         next_rdata = {24'h000000, dout[0]};
      else if (hit_do1)
         next_rdata = {24'h000000, dout[1]};
      else if (hit_di0)
         next_rdata = {24'h000000, i_din0};
      else if (hit_di1)
         next_rdata = {24'h000000, i_din1};
      else if (hit_id)
         next_rdata = {29'h00000000, card_num};
      else if (in_cnt)
         next_rdata = {13'h0000, cfg[cnt_idx].mode, cnt[cnt_idx]};
   end

   // Handshake: zero wait states, but a frozen clock holds the transfer
   assign o_pready  = i_penable & i_clock_en;
   assign o_pslverr = i_penable & err_q;
   assign o_prdata  = rdata_q;

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rdata_q <= 32'h00000000;
         err_q   <= 1'b0;
      end
      else if (i_clock_en && setup)
      begin
         rdata_q <= next_rdata;
         err_q   <= bad_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source selects; a changed field blanks one edge of that counter
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         counter_clock_select <= ccmd_pkg::RST_CLK_SEL;
         fast_select          <= ccmd_pkg::RST_FAST_SEL;
         sel_hold             <= 10'h000;
      end
      else if (i_clock_en)
      begin
         sel_hold <= 10'h000;
         if (wr_en && hit_sel)
         begin
            counter_clock_select <= i_pwdata[19:0];
            for (int k = 0; k < 10; k++)
               sel_hold[k] <= i_pwdata[2*k +: 2]
                              != counter_clock_select[k];
         end
         if (wr_en && hit_fast)
            fast_select <= i_pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output ports: byte load, or one channel set or cleared
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
         dout <= {ccmd_pkg::RST_DOUT, ccmd_pkg::RST_DOUT};
      else if (wr_en)
      begin
         if (hit_do0)
            dout[0] <= i_pwdata[7:0];
         if (hit_do1)
            dout[1] <= i_pwdata[7:0];
         if (hit_set)
            dout[ch_port] <= dout[ch_port] | ch_mask;
         if (hit_clr)
            dout[ch_port] <= dout[ch_port] & ~ch_mask;
      end
   end

   assign o_dout0 = dout[0];
   assign o_dout1 = dout[1];

   ////////////////////////////////////////////////////////////////////////
   // Fixed 8 MHz reference from the card clock
   wire fast_ref   = fast_div < 3'(ccmd_pkg::FAST_HIGH);
   wire fast_clock = fast_select ? cnt_out[10] : fast_ref;

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
         fast_div <= 3'h0;
      else if (i_clock_en)
         fast_div <= (fast_div == 3'(ccmd_pkg::FAST_DIV - 1))
                     ? 3'h0 : fast_div + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counters; clocks are sampled levels, so the mux never makes a
   // runt pulse and a select change only needs one blanked edge
   assign o_counter_out = cnt_out;

   for (genvar i = 0; i < ccmd_pkg::NUM_CNT; i++)
   begin : g_cnt
      logic edge_hit;
      logic cnt_wr;
      if (i < ccmd_pkg::NUM_MUXED)
      begin : g_mux
         logic prev_out;
         assign prev_out = (i == 0) ? 1'b0 : cnt_out[(i + 11) % 12];
         always_comb
         begin
            unique case (counter_clock_select[i])
               ccmd_pkg::SRC_EXT:  src[i] = i_ext_clock[i];
               ccmd_pkg::SRC_PREV: src[i] = prev_out;
               ccmd_pkg::SRC_FAST: src[i] = fast_clock;
               ccmd_pkg::SRC_LAST: src[i] = cnt_out[9];
            endcase
         end
         assign edge_hit = src[i] & ~src_q[i] & ~sel_hold[i];
      end
      else
      begin : g_fixed
         // Counter 11 runs from 8 MHz, counter 12 from counter 11
         assign src[i]   = (i == 10) ? fast_ref : cnt_out[10];
         assign edge_hit = src[i] & ~src_q[i];
      end

      assign cnt_wr = wr_en & in_cnt & (cnt_idx == 4'(i));

      // Load sets mode and count; source writes never reach here
      always_ff @(posedge i_clock or negedge i_arst_n)
      begin
         if (!i_arst_n)
         begin
            cfg[i]     <= '{ccmd_pkg::RST_MODE, ccmd_pkg::RST_COUNT};
            cnt[i]     <= ccmd_pkg::RST_COUNT;
            cnt_out[i] <= 1'b0;
            src_q[i]   <= 1'b0;
         end
         else if (i_clock_en)
         begin
            src_q[i] <= src[i];
            if (cnt_wr)
            begin
               cfg[i].mode  <= wr_mode;
               cfg[i].count <= i_pwdata[15:0];
               cnt[i]       <= i_pwdata[15:0];
               cnt_out[i]   <= 1'b0;
            end
            else if (edge_hit)
            begin
               // Counts below 2 reload at once; hence the host minimum
               if (cnt[i] <= 16'h0001)
               begin
                  cnt[i]     <= cfg[i].count;
                  cnt_out[i] <= ~cnt_out[i];
               end
               else
                  cnt[i] <= cnt[i] - 16'h0001;
            end
         end
      end

      a_mode_in_range: assert property (
         @(posedge i_clock) disable iff (!i_arst_n)
         cfg[i].mode <= ccmd_pkg::MODE_MAX)
         else $error("counter mode above five");
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   sequence s_sel_write;
      wr_en && hit_sel && (i_pwdata[1:0] != counter_clock_select[0]);
   endsequence
   sequence s_blank_edge;
      sel_hold[0] && !g_cnt[0].edge_hit;
   endsequence

   a_ext_route: assert property (
      counter_clock_select[0] == ccmd_pkg::SRC_EXT
      |-> src[0] == i_ext_clock[0])
      else $error("external clock not routed");

   a_first_ground: assert property (
      counter_clock_select[0] == ccmd_pkg::SRC_PREV |-> !src[0])
      else $error("counter one clock not grounded");

   a_chain_route: assert property (
      counter_clock_select[1] == ccmd_pkg::SRC_PREV
      |-> src[1] == cnt_out[0])
      else $error("previous output not routed");

   a_fast_route: assert property (
      counter_clock_select[2] == ccmd_pkg::SRC_FAST
      |-> src[2] == (fast_select ? cnt_out[10] : fast_ref))
      else $error("fast clock not routed");

   a_last_route: assert property (
      counter_clock_select[3] == ccmd_pkg::SRC_LAST
      |-> src[3] == cnt_out[9])
      else $error("counter ten output not routed");

   a_sel_keeps_cfg: assert property (
      wr_en && hit_sel |=> $stable(cfg[0]) && $stable(cfg[9]))
      else $error("source change altered counter setup");

   a_sel_glitch_free: assert property (
      s_sel_write |=> s_blank_edge)
      else $error("edge passed during source change");

   a_ch_set_one: assert property (
      wr_en && hit_set && !ch_port
      |=> dout[0] == ($past(dout[0]) | (8'h01 << $past(i_pwdata[2:0]))))
      else $error("channel set touched wrong bits");

   a_ch_clr_one: assert property (
      wr_en && hit_clr && ch_port
      |=> dout[1] == ($past(dout[1]) & ~(8'h01 << $past(i_pwdata[2:0])))
          && $stable(dout[0]))
      else $error("channel clear touched wrong bits");

   a_readback_dout: assert property (
      i_clock_en && setup && hit_do1 |=> rdata_q == {24'h000000, dout[1]})
      else $error("output port read back wrong");

endmodule // ccmd_top

/* tb/ccmd_far_model.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////
// Connector side: external clocks, inputs, jumpers
module ccmd_far_model (
   input  wire logic       i_clock,
   output logic      [9:0] o_ext_clock,
   output logic      [7:0] o_din0,
   output logic      [7:0] o_din1,
   output logic      [1:0] o_card_jumper
);
   // Clocks stand still low; inputs idle at pull-up level
   initial
   begin
      o_ext_clock   = 10'h000;
      o_din0        = 8'hFF;
      o_din1        = 8'hFF;
      o_card_jumper = 2'h0;
   end

   // Masked clocks pulse n times, w cycles high, w low
   task automatic pulse(input logic [9:0] m, input int n, input int w);
      repeat (n)
      begin
         o_ext_clock <= m;
         repeat (w) @(posedge i_clock);
         o_ext_clock <= 10'h000;
         repeat (w) @(posedge i_clock);
      end
   endtask

   // New input levels and jumper setting
   task automatic drive(input logic [15:0] d, input logic [1:0] j);
      o_din0        <= d[7:0];
      o_din1        <= d[15:8];
      o_card_jumper <= j;
   endtask
endmodule // ccmd_far_model

/* tb/tb_ccmd_top.sv */
`timescale 1ns/1ps

module tb_ccmd_top;
   logic        clk;
   logic        arst_n  = 1'b0;
   logic        clk_en  = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  ext_clk;
   logic [7:0]  din0;
   logic [7:0]  din1;
   logic [1:0]  jumper;
   logic [11:0] cnt_out;
   logic [7:0]  dout0;
   logic [7:0]  dout1;
   logic [15:0] cv [1:12];
   logic [31:0] seed    = 32'h00013B02;
   int          error_cnt = 0;
   int          compares  = 0;

   // Clock enable driven so that a freeze can be checked
   ccmd_top u_ccmd_top (
      .i_clock       (clk),
      .i_arst_n      (arst_n),
      .i_clock_en    (clk_en),
      .i_psel        (psel),
      .i_penable     (penable),
      .i_pwrite      (pwrite),
      .i_paddr       (paddr),
      .i_pwdata      (pwdata),
      .o_prdata      (prdata),
      .o_pready      (pready),
      .o_pslverr     (pslverr),
      .i_ext_clock   (ext_clk),
      .i_din0        (din0),
      .i_din1        (din1),
      .i_card_jumper (jumper),
      .o_counter_out (cnt_out),
      .o_dout0       (dout0),
      .o_dout1       (dout1)
   );

   ccmd_far_model u_ccmd_far_model (
      .i_clock       (clk),
      .o_ext_clock   (ext_clk),
      .o_din0        (din0),
      .o_din1        (din1),
      .o_card_jumper (jumper)
   );

   //////////////////////////////////////////////////
   // Helpers
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [11:0] cadr(input int n);
      return ccmd_pkg::OFS_CNT_BASE + 12'(4 * (n - 1));
   endfunction

   // Counter n always gets mode (n-1) mod 6
   function automatic logic [31:0] cw(input int n, input logic [15:0] c);
      return {13'h0000, 3'((n - 1) % 6), c};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic xe,
                      output logic [31:0] q);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      q = prdata;
      chk({30'h0, pready, pslverr}, {30'h0, 1'b1, xe});
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic xe = 1'b0);
      logic [31:0] q;
      apb(1'b1, a, d, xe, q);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] x,
                     input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, 1'b0, q);
      chk(q & m, x & m);
   endtask

   task automatic ld(input int n, input logic [15:0] c);
      cv[n] = c;
      wr(cadr(n), cw(n, c));
   endtask

   // Counters 11 and 12 run free, so only their mode is fixed
   task automatic rcnt(input int n);
      rc(cadr(n), cw(n, cv[n]), n > 10 ? 32'h00070000 : 32'hFFFFFFFF);
   endtask

   task automatic results();
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end

   //////////////////////////////////////////////////
   // Scenarios
   initial
   begin
      logic [31:0] q;
      logic [31:0] v;
      logic [7:0]  ex [2];
      logic [15:0] d;
      int          ls [5];
      ls = '{1, 2, 4, 5, 10};
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // Reset state
      rc(ccmd_pkg::OFS_CLK_SEL, 32'h0);
      rc(ccmd_pkg::OFS_FAST_SEL, 32'h0);
      chk({16'h0, dout1, dout0}, 32'h0);
      // Every jumper setting with fresh input levels
      for (int j = 0; j < 4; j++)
      begin
         v = rnd();
         u_ccmd_far_model.drive(v[15:0], 2'(j));
         repeat (4) @(posedge clk);
         rc(ccmd_pkg::OFS_CARD_ID, 32'(j + 1));
         rc(ccmd_pkg::OFS_DIN0, {24'h0, v[7:0]});
         rc(ccmd_pkg::OFS_DIN1, {24'h0, v[15:8]});
      end
      // Byte loads, then single channels 0..7 twice over
      for (int p = 0; p < 2; p++)
      begin
         v = rnd();
         ex[p] = v[7:0];
         wr(ccmd_pkg::OFS_DOUT0 + 12'(4 * p), {24'h0, v[7:0]});
      end
      for (int i = 0; i < 16; i++)
      begin
         v = rnd();
         ex[v[0]][3'(i)] = v[1];
         wr(v[1] ? ccmd_pkg::OFS_CH_SET : ccmd_pkg::OFS_CH_CLR,
            {28'h0, v[0], 3'(i)});
         chk({16'h0, dout1, dout0}, {16'h0, ex[1], ex[0]});
      end
      rc(ccmd_pkg::OFS_DOUT0, {24'h0, ex[0]});
      rc(ccmd_pkg::OFS_DOUT1, {24'h0, ex[1]});
      // All counters, every mode, counts at both ends
      for (int n = 1; n <= 12; n++)
      begin
         v = rnd();
         ld(n, n == 1 ? 16'hFFFF : n == 2 ? 16'h0002
                : v[15:0] | 16'h0002);
      end
      for (int n = 1; n <= 12; n++)
         rcnt(n);
      // Mode 6 refused; unmapped word refused
      wr(cadr(3), 32'h00061234, 1'b1);
      rcnt(3);
      apb(1'b0, 12'h030, 32'h0, 1'b1, q);
      // Quiet codes only (0, 1, 3): setup must survive
      v = rnd();
      v = v | ((v >> 1) & 32'h00055555);
      wr(ccmd_pkg::OFS_CLK_SEL, {12'h0, v[19:0]});
      rc(ccmd_pkg::OFS_CLK_SEL, {12'h0, v[19:0]});
      for (int n = 1; n <= 10; n++)
         rcnt(n);
      // 1, 4, 10 external; 2 from 1; 5 from 10
      wr(ccmd_pkg::OFS_CLK_SEL, 32'h00000304);
      ld(1, 16'h0002);
      ld(2, 16'h000A);
      ld(4, 16'h0005);
      ld(5, 16'h000A);
      ld(10, 16'h0002);
      u_ccmd_far_model.pulse(10'h209, 2, 2);
      repeat (3) @(posedge clk);
      chk({22'h0, cnt_out[9:0]}, 32'h00000201);
      u_ccmd_far_model.pulse(10'h209, 2, 2);
      repeat (3) @(posedge clk);
      cv[2] = 16'h0009;
      cv[4] = 16'h0001;
      cv[5] = 16'h0009;
      foreach (ls[i])
         rcnt(ls[i]);
      // Counter 1 on code 1 sees ground, even with slow pulses
      wr(ccmd_pkg::OFS_CLK_SEL, 32'h00000001);
      ld(1, 16'h0005);
      u_ccmd_far_model.pulse(10'h001, 3, 3);
      rcnt(1);
      // Fast clock from a stalled counter 11, then from 8 MHz
      wr(ccmd_pkg::OFS_FAST_SEL, 32'h1);
      rc(ccmd_pkg::OFS_FAST_SEL, 32'h1);
      ld(11, 16'hFFFF);
      wr(ccmd_pkg::OFS_CLK_SEL, 32'h00000800);
      ld(6, 16'h03E8);
      repeat (50) @(posedge clk);
      rcnt(6);
      chk({31'h0, cnt_out[10]}, 32'h0);
      wr(ccmd_pkg::OFS_FAST_SEL, 32'h0);
      repeat (50) @(posedge clk);
      apb(1'b0, cadr(6), 32'h0, 1'b0, q);
      d = 16'h03E8 - q[15:0];
      chk({31'h0, d >= 16'h0009 && d <= 16'h000E}, 32'h1);
      // Enable low: counter 6 must hold to within one count across the freeze
      apb(1'b0, cadr(6), 32'h0, 1'b0, q);
      clk_en <= 1'b0;
      repeat (30) @(posedge clk);
      clk_en <= 1'b1;
      apb(1'b0, cadr(6), 32'h0, 1'b0, v);
      d = q[15:0] - v[15:0];
      chk({31'h0, d <= 16'h0001}, 32'h1);
      results();
   end
endmodule // tb_ccmd_top
